// *** rtl/prox_cal_pkg.sv ***
// package: register map, field layouts and constants of the offset calibration block
package prox_cal_pkg;
  localparam logic [7:0] ADDR_RANGE_EXT = 8'hd8;
  localparam logic [7:0] ADDR_CAL_CFG = 8'hd9;
  localparam logic [7:0] ADDR_CAL_STAT = 8'hdc;
  localparam logic [7:0] ADDR_IRQ_EN = 8'hdd;
  localparam logic [7:0] ADDR_OFFSET_MAG = 8'hc0;
  localparam logic [7:0] ADDR_OFFSET_SIGN = 8'hc1;
  localparam int RANGE_EN_BIT = 5;
  localparam int STEP_MSB = 4;
  localparam int GOAL_LSB = 5;
  localparam int AUTO_DEC_BIT = 3;
  localparam int AVG_MSB = 2;
  localparam int FLAG_DEC_BIT = 2;
  localparam int FLAG_DONE_BIT = 0;
  localparam int IRQ_EN_LSB = 2;
  localparam logic [7:0] RANGE_EXT_RESET = 8'h00;
  localparam logic [7:0] CAL_CFG_RESET = 8'h50;
  localparam logic [7:0] CAL_CFG_RSVD_MASK = 8'h10;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [2:0] AVG_MAX_CODE = 3'h4;
  localparam logic [8:0] NEAR_MAX = 9'h1ff;
  localparam int IRQ_SRC_N = 6;
  localparam int IRQ_CAL_IDX = 1;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_MEASURE = 2'b01,
    CAL_WAIT = 2'b10,
    CAL_FINISH = 2'b11
  } cal_state_t;
endpackage : prox_cal_pkg

// *** rtl/prox_offset_calibration_ctrl.sv ***
// prox_offset_calibration_ctrl: offset calibration control, averaging, flags and interrupt enables
// Summary of operation
// R1: range-extension enable applies selected step count, else nominal range only
// R2: five-bit step field adds 0 to 31 steps, resets to zero
// R3: calibration result stored in offset magnitude and sign for host read
// R4: three-bit goal code, reset 2, maps to targets 3 through 511
// R5: binary search settles no-object data near selected target
// R6: auto-decrement lowers offset, holding it at minus 255, whenever a result bottoms out at zero while no calibration is running
// R7: averaging code 0 off, 1 to 4 give 2,4,8,16 samples
// R8: each averaged sample requests the full programmed emitter pulse burst
// R9: mean of averaged samples is written straight to the result
// R10: auto-decrement sets the auto_decrement_flag flag
// R11: flag clears on write-one or when auto-decrement enable is cleared
// R12: done mirror always copies the calibration interrupt flag
// R13: six interrupt enables at bits 7 to 2, all reset zero
// R14: host writes reserved bits with their reset values
// R15: start bit launches a binary search on the offset
// R16: completion loads offset registers and raises the calibration interrupt flag
// R17: offset is eight-bit magnitude plus sign, range plus or minus 255
// R18: a source drives the interrupt only when flag and enable both set
`timescale 1ns/1ps
`default_nettype none
module prox_offset_calibration_ctrl
  import prox_cal_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_cal_start,
  input wire logic i_cal_irq_flag,
  input wire logic i_sample_valid,
  input wire logic [8:0] i_sample,
  output logic o_pulse_burst,
  output logic [8:0] o_near_result,
  output logic o_result_valid,
  output logic o_set_cal_irq,
  output logic [7:0] o_offset_magnitude,
  output logic o_offset_sign,
  output logic o_range_ext_active,
  output logic [4:0] o_range_steps,
  input wire logic [IRQ_SRC_N-1:0] i_irq_flags,
  output logic o_irq
);
  localparam int SUM_W = 13;

  logic [7:0] range_ext, next_range_ext;
  logic [7:0] cal_cfg, next_cal_cfg;
  logic [7:0] irq_en, next_irq_en;
  logic dec_flag, next_dec_flag;
  logic [7:0] off_mag, next_off_mag;
  logic off_sign, next_off_sign;
  cal_state_t state, next_state;
  logic [3:0] bit_idx, next_bit_idx;
  logic [SUM_W-1:0] acc, next_acc;
  logic [4:0] samp_cnt, next_samp_cnt;
  logic [8:0] result, next_result;
  logic result_valid, next_result_valid;
  logic pulse_burst, next_pulse_burst;
  logic set_irq, next_set_irq;

  // target count for a goal code: 2^(code+2) - 1
  function automatic logic [8:0] goal_target(input logic [2:0] code);
    goal_target = 9'((10'h004 << code) - 10'h001); // R4
  endfunction : goal_target

  // log2 of the sample count; reserved codes treated as no averaging
  function automatic logic [2:0] avg_shift(input logic [2:0] code);
    avg_shift = (code > AVG_MAX_CODE) ? 3'h0 : code; // R7
  endfunction : avg_shift

  logic [2:0] shift;
  logic [4:0] n_samples;
  logic [SUM_W-1:0] sum_now;
  logic [8:0] mean_now;
  logic [8:0] goal;
  logic auto_en, bottom_out, avg_done, cfg_wr;
  assign shift = avg_shift(cal_cfg[AVG_MSB:0]);
  assign n_samples = 5'(5'h01 << shift);
  assign sum_now = acc + SUM_W'(i_sample);
  assign mean_now = 9'(sum_now >> shift); // R9
  assign avg_done = i_sample_valid && (samp_cnt + 5'h01 == n_samples);
  assign auto_en = cal_cfg[AUTO_DEC_BIT];
  assign cfg_wr = i_reg_wr && i_reg_addr == ADDR_CAL_CFG;
  assign bottom_out = avg_done && mean_now == 9'h000;
  assign goal = goal_target(cal_cfg[7:GOAL_LSB]); // R4

  always_comb begin
    next_range_ext = range_ext;
    next_cal_cfg = cal_cfg;
    next_irq_en = irq_en;
    next_off_mag = off_mag;
    next_off_sign = off_sign;
    next_dec_flag = dec_flag;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        ADDR_RANGE_EXT: next_range_ext = i_reg_wdata;
        ADDR_CAL_CFG: next_cal_cfg = i_reg_wdata;
        ADDR_IRQ_EN: next_irq_en = i_reg_wdata; // R13
        ADDR_OFFSET_MAG: next_off_mag = i_reg_wdata;
        ADDR_OFFSET_SIGN: next_off_sign = i_reg_wdata[0];
        ADDR_CAL_STAT: begin
          if (i_reg_wdata[FLAG_DEC_BIT]) begin
            next_dec_flag = 1'b0; // R11
          end
        end
        default: ;
      endcase
    end
    // a cleared enable drops the flag; a set in the same cycle still wins below
    if (cfg_wr && !i_reg_wdata[AUTO_DEC_BIT]) begin
      next_dec_flag = 1'b0; // R11
    end
    // decrement moves the signed offset one count toward more counts added
    if (auto_en && bottom_out && state == CAL_IDLE) begin
      if (off_sign || off_mag == 8'h00) begin
        next_off_sign = 1'b1;
        next_off_mag = (off_mag == 8'hff) ? off_mag : off_mag + 8'h01; // R6 R17
      end else begin
        next_off_mag = off_mag - 8'h01; // R6
      end
      next_dec_flag = 1'b1; // R10
    end
    next_state = state;
    next_bit_idx = bit_idx;
    next_set_irq = 1'b0;
    next_pulse_burst = 1'b0;
    unique case (state)
      CAL_IDLE: begin
        if (i_cal_start) begin
          next_state = CAL_MEASURE; // R15
          next_bit_idx = 4'h8;
          next_off_sign = 1'b0;
          next_off_mag = 8'h00;
        end
      end
      CAL_MEASURE: begin
        // trial: set the bit under test, sign searched first
        if (bit_idx == 4'h8) begin
          next_off_sign = 1'b1;
        end else begin
          next_off_mag[bit_idx[2:0]] = 1'b1;
        end
        next_state = CAL_WAIT;
      end
      CAL_WAIT: begin
        if (avg_done) begin
          // sign trial runs at zero magnitude: stay negative only while data sits below goal
          if (bit_idx == 4'h8) begin
            if (mean_now >= goal) begin // R5
              next_off_sign = 1'b0;
            end
          // a magnitude bit that overshoots the goal in its direction is dropped
          end else if (off_sign ? (mean_now > goal) : (mean_now < goal)) begin // R5
            next_off_mag[bit_idx[2:0]] = 1'b0;
          end
          if (bit_idx == 4'h0) begin
            next_state = CAL_FINISH;
          end else begin
            next_bit_idx = bit_idx - 4'h1;
            next_state = CAL_MEASURE;
          end
        end
      end
      CAL_FINISH: begin
        next_set_irq = 1'b1; // R16 R3
        next_state = CAL_IDLE;
      end
      default: next_state = CAL_IDLE;
    endcase
    next_acc = acc;
    next_samp_cnt = samp_cnt;
    next_result = result;
    next_result_valid = 1'b0;
    if (state == CAL_MEASURE || (state == CAL_IDLE && !i_cal_start && samp_cnt == 5'h00 && !i_sample_valid)) begin
      next_pulse_burst = (state == CAL_MEASURE); // R8
    end
    if (i_sample_valid) begin
      if (avg_done) begin
        next_acc = '0;
        next_samp_cnt = 5'h00;
        next_result = mean_now; // R9
        next_result_valid = 1'b1;
      end else begin
        next_acc = sum_now;
        next_samp_cnt = samp_cnt + 5'h01;
        next_pulse_burst = 1'b1; // R8
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      range_ext <= RANGE_EXT_RESET;
      cal_cfg <= CAL_CFG_RESET;
      irq_en <= IRQ_EN_RESET;
      dec_flag <= 1'b0;
      off_mag <= 8'h00;
      off_sign <= 1'b0;
      state <= CAL_IDLE;
      bit_idx <= 4'h0;
      acc <= '0;
      samp_cnt <= 5'h00;
      result <= 9'h000;
      result_valid <= 1'b0;
      pulse_burst <= 1'b0;
      set_irq <= 1'b0;
    end else begin
      range_ext <= next_range_ext;
      cal_cfg <= next_cal_cfg;
      irq_en <= next_irq_en;
      dec_flag <= next_dec_flag;
      off_mag <= next_off_mag;
      off_sign <= next_off_sign;
      state <= next_state;
      bit_idx <= next_bit_idx;
      acc <= next_acc;
      samp_cnt <= next_samp_cnt;
      result <= next_result;
      result_valid <= next_result_valid;
      pulse_burst <= next_pulse_burst;
      set_irq <= next_set_irq;
    end
  end

  always_comb begin
    unique case (i_reg_addr)
      ADDR_RANGE_EXT: o_reg_rdata = range_ext;
      ADDR_CAL_CFG: o_reg_rdata = cal_cfg;
      ADDR_CAL_STAT: o_reg_rdata = {5'h00, dec_flag, 1'b0, i_cal_irq_flag}; // R12 R10
      ADDR_IRQ_EN: o_reg_rdata = irq_en;
      ADDR_OFFSET_MAG: o_reg_rdata = off_mag;
      ADDR_OFFSET_SIGN: o_reg_rdata = {7'h00, off_sign};
      default: o_reg_rdata = 8'h00;
    endcase
  end

  assign o_range_ext_active = range_ext[RANGE_EN_BIT]; // R1
  assign o_range_steps = range_ext[RANGE_EN_BIT] ? range_ext[STEP_MSB:0] : 5'h00; // R1 R2
  assign o_offset_magnitude = off_mag;
  assign o_offset_sign = off_sign;
  assign o_near_result = result;
  assign o_result_valid = result_valid;
  assign o_pulse_burst = pulse_burst;
  assign o_set_cal_irq = set_irq;
  assign o_irq = |(i_irq_flags & irq_en[7:IRQ_EN_LSB]); // R18

  a_flag_set_on_dec: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    auto_en && bottom_out && state == CAL_IDLE |=> dec_flag) // R10
    else $error("adjusted flag not set after auto decrement");
  a_flag_clear_w1: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    i_reg_wr && i_reg_addr == ADDR_CAL_STAT && i_reg_wdata[FLAG_DEC_BIT] && !bottom_out |=> !dec_flag) // R11
    else $error("adjusted flag not cleared by write one");
  a_done_mirror: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    i_reg_addr == ADDR_CAL_STAT |-> o_reg_rdata[FLAG_DONE_BIT] == i_cal_irq_flag) // R12
    else $error("done mirror differs from interrupt flag");
  a_range_gate: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    !range_ext[RANGE_EN_BIT] |-> o_range_steps == 5'h00) // R1 R2
    else $error("range steps applied while disabled");
  a_irq_gate: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_irq |-> (i_irq_flags & irq_en[7:IRQ_EN_LSB]) != '0) // R18
    else $error("interrupt without enabled flag");
  a_cal_ends: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    state == CAL_FINISH |=> o_set_cal_irq && state == CAL_IDLE) // R16
    else $error("calibration end did not raise flag");
  a_start_search: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    state == CAL_IDLE && i_cal_start |=> state == CAL_MEASURE ##1 state == CAL_WAIT) // R15
    else $error("start did not launch search");
  a_avg_mean: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    avg_done |=> o_result_valid && o_near_result == $past(mean_now)) // R9
    else $error("averaged result not written");
  a_goal_reset: assert property (@(posedge i_ref_clk)
    $rose(i_arst_n) |-> cal_cfg == CAL_CFG_RESET) // R4
    else $error("goal code reset wrong");
  a_regs_reset: assert property (@(posedge i_ref_clk)
    $rose(i_arst_n) |-> irq_en == IRQ_EN_RESET && range_ext == RANGE_EXT_RESET) // R13 R2
    else $error("enable or range register reset wrong");
  a_finish_pulse_once: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_set_cal_irq |=> !o_set_cal_irq) // R16
    else $error("calibration done pulse longer than one cycle");
  a_start_clears_offset: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    state == CAL_IDLE && i_cal_start |=> off_mag == 8'h00 && !off_sign) // R15
    else $error("start did not clear the offset");
  a_cfg_clear_flag: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    cfg_wr && !i_reg_wdata[AUTO_DEC_BIT] && !(auto_en && bottom_out && state == CAL_IDLE) |=> !dec_flag) // R11
    else $error("adjusted flag not cleared by enable clear");
  a_burst_in_measure: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    state == CAL_MEASURE |=> o_pulse_burst) // R8
    else $error("no emitter burst for calibration trial");
  a_result_hold: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    !avg_done |=> $stable(o_near_result)) // R9
    else $error("result changed without a finished average");
  a_steps_follow: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    range_ext[RANGE_EN_BIT] |-> o_range_steps == range_ext[STEP_MSB:0]) // R1 R2
    else $error("range steps differ from field while enabled");
  a_dec_step_down: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    auto_en && bottom_out && state == CAL_IDLE && !i_cal_start && !off_sign && off_mag != 8'h00
    |=> off_mag == $past(off_mag) - 8'h01) // R6
    else $error("auto decrement did not lower the offset by one");
endmodule : prox_offset_calibration_ctrl
`default_nettype wire

// *** verification/afe_model.sv ***
// afe_model: behavioural converter answering each conversion request with one sample
`timescale 1ns/1ps
`default_nettype none
module afe_model #(
  parameter int LAT = 3
) (
  input wire logic i_clk,
  input wire logic i_kick,
  input wire logic i_burst,
  input wire logic i_jitter,
  input wire logic [8:0] i_base,
  input wire logic [7:0] i_mag,
  input wire logic i_sign,
  output logic o_valid,
  output logic [8:0] o_sample
);
  int pend = 0;
  int level;
  logic flip = 1'b0;
  initial o_valid = 1'b0;
  initial o_sample = 9'h000;
  // positive offset pulls the reading down; clamped to the converter range
  always_comb begin
    level = i_sign ? int'(i_base) + int'(i_mag) : int'(i_base) - int'(i_mag);
    if (level < 0) level = 0;
    if (level > 511) level = 511;
  end
  always @(posedge i_clk) begin
    if (i_kick === 1'b1 || i_burst === 1'b1) pend <= LAT;
    else if (pend > 0) pend <= pend - 1;
  end
  always @(negedge i_clk) begin
    o_valid <= (pend == 1);
    if (pend == 1) begin
      o_sample <= 9'(level + ((i_jitter && flip) ? 2 : 0));
      flip <= i_jitter ? ~flip : 1'b0;
    end else begin
      // never leave a stale sample on the bus between conversions
      o_sample <= ~o_sample;
    end
  end
endmodule : afe_model
`default_nettype wire

// *** verification/prox_offset_calibration_ctrl_test.sv ***
// testbench for the offset calibration control block
`timescale 1ns/1ps
`default_nettype none
module prox_offset_calibration_ctrl_test;
  import prox_cal_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, cal_start = 1'b0, cal_flag = 1'b0, kick = 1'b0, jit = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, mag;
  logic [8:0] base = 9'h064, samp, result;
  logic [IRQ_SRC_N-1:0] flags = 6'h00;
  logic svalid, burst, rvalid, set_irq, sign, ext_act, irq;
  logic [4:0] steps;
  int error_cnt = 0, cmp_count = 0;
  initial forever #5 clk = ~clk;
  prox_offset_calibration_ctrl dut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_reg_wr(reg_wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_cal_start(cal_start), .i_cal_irq_flag(cal_flag),
    .i_sample_valid(svalid), .i_sample(samp), .o_pulse_burst(burst), .o_near_result(result),
    .o_result_valid(rvalid), .o_set_cal_irq(set_irq), .o_offset_magnitude(mag), .o_offset_sign(sign),
    .o_range_ext_active(ext_act), .o_range_steps(steps), .i_irq_flags(flags), .o_irq(irq));
  afe_model afe (.i_clk(clk), .i_kick(kick), .i_burst(burst), .i_jitter(jit), .i_base(base), .i_mag(mag),
    .i_sign(sign), .o_valid(svalid), .o_sample(samp));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    #1 check({1'b0, rdata}, {1'b0, exp});
  endtask : rd
  // starts a conversion or a calibration and counts bursts until it completes
  task automatic run_to(input bit cal, output int bursts);
    int n;
    bursts = 0;
    @(negedge clk);
    if (cal) cal_start = 1'b1;
    else kick = 1'b1;
    @(negedge clk);
    cal_start = 1'b0;
    kick = 1'b0;
    for (n = 0; n < 5000; n++) begin
      if ((cal ? set_irq : rvalid) === 1'b1) break;
      if (burst === 1'b1) bursts++;
      @(negedge clk);
    end
    if (n == 5000) begin
      error_cnt++;
      $display("Error at %0t: wait ran out %h %h", $time, n, 0);
      wrap_up();
    end
  endtask : run_to
  function automatic logic [8:0] est(input logic [8:0] b, input logic [7:0] m, input logic s);
    int v;
    v = s ? int'(b) + int'(m) : int'(b) - int'(m);
    if (v < 0) v = 0;
    if (v > 511) v = 511;
    return 9'(v);
  endfunction : est
  task automatic t_regs();
    rd(ADDR_RANGE_EXT, 8'h00);
    rd(ADDR_CAL_CFG, 8'h50);
    rd(ADDR_IRQ_EN, 8'h00);
    rd(ADDR_CAL_STAT, 8'h00);
    rd(ADDR_OFFSET_MAG, 8'h00);
    wr(ADDR_RANGE_EXT, 8'h3f);
    check({3'h0, ext_act, steps}, 9'h03f);
    wr(ADDR_RANGE_EXT, 8'h1f);
    check({3'h0, ext_act, steps}, 9'h000);
    wr(8'h00, 8'hff);
    rd(ADDR_RANGE_EXT, 8'h1f);
    rd(8'h00, 8'h00);
    wr(ADDR_IRQ_EN, 8'hfc);
    rd(ADDR_IRQ_EN, 8'hfc);
    $display("register test done");
  endtask : t_regs
  task automatic t_irq();
    for (int i = 0; i < IRQ_SRC_N; i++) begin
      flags = 6'h01 << i;
      wr(ADDR_IRQ_EN, 8'hfc & ~(8'h04 << i));
      check({8'h00, irq}, 9'h000);
      wr(ADDR_IRQ_EN, 8'h04 << i);
      check({8'h00, irq}, 9'h001);
    end
    flags = 6'h00;
    $display("interrupt enable test done");
  endtask : t_irq
  task automatic t_average();
    int b;
    jit = 1'b1;
    for (int c = 0; c <= 4; c++) begin
      wr(ADDR_CAL_CFG, 8'h50 | 8'(c));
      run_to(1'b0, b);
      check(result, base + 9'(c != 0));
      check(9'(b), 9'((1 << c) - 1));
    end
    jit = 1'b0;
    $display("averaging test done");
  endtask : t_average
  task automatic t_cal();
    int b, tgt;
    for (int g = 0; g < 8; g++) begin
      tgt = (4 << g) - 1;
      base = (tgt + 100 > 511) ? 9'h1ff : 9'(tgt + 100);
      wr(ADDR_CAL_CFG, 8'h10 | 8'(g << 5));
      run_to(1'b1, b);
      check(est(base, mag, sign), 9'(tgt));
      check(9'(b), 9'h009);
      if (g == 2) begin
        rd(ADDR_OFFSET_MAG, 8'h64);
        rd(ADDR_OFFSET_SIGN, 8'h00);
      end
    end
    base = 9'h005;
    wr(ADDR_CAL_CFG, 8'h70);
    run_to(1'b1, b);
    check(est(base, mag, sign), 9'h01f);
    rd(ADDR_OFFSET_SIGN, 8'h01);
    cal_flag = 1'b1;
    rd(ADDR_CAL_STAT, 8'h01);
    cal_flag = 1'b0;
    rd(ADDR_CAL_STAT, 8'h00);
    $display("calibration test done");
  endtask : t_cal
  task automatic t_auto();
    int b;
    base = 9'h000;
    wr(ADDR_OFFSET_MAG, 8'h00);
    wr(ADDR_OFFSET_SIGN, 8'h00);
    wr(ADDR_CAL_CFG, 8'h58);
    run_to(1'b0, b);
    rd(ADDR_OFFSET_SIGN, 8'h01);
    rd(ADDR_OFFSET_MAG, 8'h01);
    rd(ADDR_CAL_STAT, 8'h04);
    wr(ADDR_CAL_STAT, 8'h04);
    rd(ADDR_CAL_STAT, 8'h00);
    wr(ADDR_OFFSET_MAG, 8'h00);
    wr(ADDR_OFFSET_SIGN, 8'h00);
    run_to(1'b0, b);
    rd(ADDR_CAL_STAT, 8'h04);
    wr(ADDR_CAL_CFG, 8'h50);
    rd(ADDR_CAL_STAT, 8'h00);
    $display("auto decrement test done");
  endtask : t_auto
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    t_regs();
    t_irq();
    t_average();
    t_cal();
    t_auto();
    wrap_up();
  end
endmodule : prox_offset_calibration_ctrl_test
`default_nettype wire
